// file: rvf_pkg.sv
package rvf_pkg;

    localparam logic [11:0] VIDEO_SET_OFS   = 12'ha80;
    localparam logic [11:0] VIDEO_CLR_OFS   = 12'ha84;
    localparam logic [11:0] LINK_SET_OFS    = 12'ha88;
    localparam logic [11:0] LINK_CLR_OFS    = 12'ha8c;
    localparam logic [11:0] LINK_CFG_OFS    = 12'h0f4;
    localparam logic [11:0] CTX_CTRL_SET    = 12'h400;
    localparam logic [11:0] CTX_CTRL_CLR    = 12'h404;
    localparam logic [11:0] CTX_STRIDE      = 12'h020;
    localparam int          KEEP_HDR_BIT    = 30;
    localparam int          STRIP_BIT       = 0;
    localparam int          SYNC_BIT        = 1;
    localparam int          CTX_FIELD_W     = 4;
    localparam int          NUM_CTX         = 4;
    localparam logic [31:0] VIDEO_MASK      = 32'h0000_3333;
    localparam logic [31:0] LINK_MASK       = 32'h0000_ffff;
    localparam logic [31:0] EEPROM_MASK     = 32'h0000_ffff;
    localparam logic [31:0] VIDEO_RESET     = 32'h0000_0000;
    localparam logic [31:0] LINK_RESET      = 32'h0000_0000;
    localparam logic [1:0]  BRANCH_SYNC     = 2'h1;
    localparam logic [7:0]  FS_BYTE0        = 8'h1f;
    localparam logic [3:0]  FS_NIBBLE       = 4'h7;
    localparam logic [2:0]  STRIP_QUADS     = 3'h2;
    localparam logic [2:0]  FS_QUAD         = 3'h2;
    localparam int          FIFO_DEPTH      = 16;

    typedef struct packed {
        logic [31:0] data;
        logic [1:0]  ctx;
        logic        last;
    } rvf_pkt_s;

    typedef struct packed {
        logic [31:0] data;
        logic [1:0]  ctx;
        logic        frame_start;
        logic        last;
    } rvf_word_s;

    typedef struct packed {
        logic [31:0] video;
        logic [31:0] link;
        logic [3:0]  keep;
        logic [2:0]  idx;
        logic        drop;
        logic [3:0]  wait_fs;
        logic [3:0]  branch;
        logic [31:0] rdata;
        logic        ack;
    } rvf_state_s;

endpackage

// file: rvf_frame_sync.sv
// Summary of operation
// [RL1] video register bits 31-14 read zero, writes to them ignored
// [RL2] reserved pairs 11-10, 7-6, 3-2 of video register read zero
// [RL3] strip bit of context n drops first two payload quadlets
// [RL4] sync bit with buffer-fill and branch 01b holds storing until frame start
// [RL5] frame start out of place in buffer branches context to frame branch pointer
// [RL6] sync bit acts only while same context strip bit is set
// [RL7] keep-header bit of context disables its strip and sync bits
// [RL8] keep-header bit lives in context control set/clear pair 400h+20h*n
// [RL9] link tuning register has set/clear alias of config offset F4h storage
// [RL10] software finishes link tuning setup before setting link power enable
// [RL11] eeprom load writes designated link tuning bits during initialisation
// [RL12] software changes video bits only while context active and run are zero
// [RL13] frame start is third quadlet first bytes 1Fh then low nibble 7h
// [RL14] set alias sets ones, clear alias clears ones, both read current value
`timescale 1ns/10ps

module rvf_fifo
    import rvf_pkg::*;
#(
    parameter int W = 36,
    parameter int D = 16
)(
    input  wire logic         core_clk,
    input  wire logic         rst_b,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
    } rvf_fifo_s;
    rvf_fifo_s      f_q;
    rvf_fifo_s      f_d;
    logic [W-1:0]   mem [D];
    logic           push;
    logic           pop;

    assign in_ready  = (f_q.cnt != (AW+1)'(D));
    assign out_valid = (f_q.cnt != '0);
    assign out_data  = mem[f_q.rp];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_comb
    begin
        f_d = f_q;
        if (push)
            f_d.wp = AW'(f_q.wp + 1'b1);
        if (pop)
            f_d.rp = AW'(f_q.rp + 1'b1);
        f_d.cnt = (AW+1)'(f_q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            f_q <= '0;
        else
            f_q <= f_d;
        if (push)
            mem[f_q.wp] <= in_data;
    end
endmodule

module rvf_frame_sync
    import rvf_pkg::*;
(
    input  wire logic         core_clk,
    input  wire logic         rst_b,
    input  wire logic         reg_req,
    input  wire logic         reg_we,
    input  wire logic         reg_cfg_sel,
    input  wire logic [11:0]  reg_addr,
    input  wire logic [31:0]  reg_wdata,
    output logic [31:0]       reg_rdata,
    output logic              reg_ack,
    input  wire logic         eeprom_valid,
    input  wire logic [31:0]  eeprom_data,
    input  wire logic [3:0]   desc_buffer_fill,
    input  wire logic [7:0]   desc_branch,
    input  wire logic [3:0]   buf_at_start,
    input  wire logic         pkt_valid,
    output logic              pkt_ready,
    input  wire rvf_pkt_s     pkt,
    output logic              out_valid,
    input  wire logic         out_ready,
    output rvf_word_s         out_word,
    output logic [3:0]        frame_branch
);
    rvf_state_s s_q;
    rvf_state_s s_d;
    logic [3:0] strip_eff;
    logic [3:0] sync_eff;
    logic       take;
    logic       push;
    logic       fs;
    logic       strip_c;
    logic       sync_c;
    rvf_word_s  in_word;

    assign reg_rdata    = s_q.rdata;
    assign reg_ack      = s_q.ack;
    assign frame_branch = s_q.branch;
    assign take         = pkt_valid & pkt_ready;
    assign strip_c      = strip_eff[pkt.ctx];
    assign sync_c       = sync_eff[pkt.ctx];
    // big-endian bytes: first byte in 31:24, second in 23:16
    assign fs = (s_q.idx == FS_QUAD) && (pkt.data[31:24] == FS_BYTE0) && (pkt.data[19:16] == FS_NIBBLE); // RL13
    assign in_word = '{data: pkt.data, ctx: pkt.ctx, frame_start: fs, last: pkt.last};

    always_comb
    begin
        for (int n = 0; n < NUM_CTX; n++)
        begin
            strip_eff[n] = s_q.video[CTX_FIELD_W*n+STRIP_BIT] & ~s_q.keep[n]; // RL7
            sync_eff[n]  = s_q.video[CTX_FIELD_W*n+SYNC_BIT] & strip_eff[n] // RL6
                         & desc_buffer_fill[n] & (desc_branch[2*n +: 2] == BRANCH_SYNC); // RL4
        end
    end

    always_comb
    begin
        s_d        = s_q;
        s_d.ack    = reg_req & ~reg_we;
        s_d.branch = '0;
        push       = take & ~s_q.drop & ~(strip_c & (s_q.idx < STRIP_QUADS)); // RL3
        if (reg_req && reg_we)
        begin
            if (reg_addr == VIDEO_SET_OFS)
                s_d.video = s_q.video | (reg_wdata & VIDEO_MASK); // RL1 RL2 RL14
            else if (reg_addr == VIDEO_CLR_OFS)
                s_d.video = s_q.video & ~(reg_wdata & VIDEO_MASK); // RL14
            else if (reg_addr == LINK_SET_OFS)
                s_d.link = s_q.link | (reg_wdata & LINK_MASK); // RL9 RL14
            else if (reg_addr == LINK_CLR_OFS)
                s_d.link = s_q.link & ~(reg_wdata & LINK_MASK); // RL9 RL14
            else if (reg_cfg_sel && reg_addr == LINK_CFG_OFS)
                s_d.link = reg_wdata & LINK_MASK; // RL9
            for (int n = 0; n < NUM_CTX; n++)
            begin
                if (reg_addr == 12'(CTX_CTRL_SET + n*CTX_STRIDE) && reg_wdata[KEEP_HDR_BIT])
                    s_d.keep[n] = 1'b1; // RL8
                if (reg_addr == 12'(CTX_CTRL_CLR + n*CTX_STRIDE) && reg_wdata[KEEP_HDR_BIT])
                    s_d.keep[n] = 1'b0; // RL8
            end
        end
        if (reg_req && !reg_we)
        begin
            s_d.rdata = '0;
            if (reg_addr == VIDEO_SET_OFS || reg_addr == VIDEO_CLR_OFS)
                s_d.rdata = s_q.video & VIDEO_MASK; // RL1 RL2 RL14
            else if (reg_addr == LINK_SET_OFS || reg_addr == LINK_CLR_OFS)
                s_d.rdata = s_q.link; // RL14
            else if (reg_cfg_sel && reg_addr == LINK_CFG_OFS)
                s_d.rdata = s_q.link; // RL9
            for (int n = 0; n < NUM_CTX; n++)
            begin
                if (reg_addr == 12'(CTX_CTRL_SET + n*CTX_STRIDE) || reg_addr == 12'(CTX_CTRL_CLR + n*CTX_STRIDE))
                    s_d.rdata[KEEP_HDR_BIT] = s_q.keep[n]; // RL8
            end
        end
        if (eeprom_valid)
            s_d.link = (s_d.link & ~EEPROM_MASK) | (eeprom_data & EEPROM_MASK); // RL11
        // re-arm the frame wait whenever sync is not in force
        for (int n = 0; n < NUM_CTX; n++)
        begin
            if (!sync_eff[n])
                s_d.wait_fs[n] = 1'b1;
        end
        if (take && sync_c && s_q.idx == FS_QUAD)
        begin
            if (fs && s_q.wait_fs[pkt.ctx])
                s_d.wait_fs[pkt.ctx] = 1'b0; // RL4
            else if (fs && !buf_at_start[pkt.ctx])
                s_d.branch[pkt.ctx] = 1'b1; // RL5
            else if (!fs && s_q.wait_fs[pkt.ctx])
            begin
                s_d.drop = 1'b1; // RL4
                push     = 1'b0;
            end
        end
        if (take)
        begin
            s_d.idx = pkt.last ? 3'h0 : ((s_q.idx == 3'h7) ? 3'h7 : 3'(s_q.idx + 3'h1));
            if (pkt.last)
                s_d.drop = 1'b0;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            s_q <= '{video: VIDEO_RESET, link: LINK_RESET, wait_fs: 4'hf, default: '0};
        else
            s_q <= s_d;
    end

    rvf_fifo #(.W($bits(rvf_word_s)), .D(FIFO_DEPTH)) u_fifo (
        .core_clk  (core_clk),
        .rst_b     (rst_b),
        .in_valid  (push),
        .in_ready  (pkt_ready),
        .in_data   (in_word),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (out_word)
    );

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    video_rsvd_zero_a: assert property ((s_q.video & ~VIDEO_MASK) == 32'h0) // RL1
        else $error("video reserved bits not zero");
    video_read_a: assert property (reg_req && !reg_we && reg_addr == VIDEO_CLR_OFS |=>
            reg_ack && reg_rdata[11:10] == 2'h0 && reg_rdata[7:6] == 2'h0 && reg_rdata[3:2] == 2'h0) // RL2
        else $error("reserved pair read nonzero");
    strip_drop_a: assert property (take && strip_c && s_q.idx < STRIP_QUADS |-> !push) // RL3
        else $error("stripped quadlet stored");
    sync_hold_a: assert property (take && sync_c && s_q.wait_fs[pkt.ctx] && !fs && s_q.idx >= FS_QUAD
            |-> !push ##1 (s_q.drop || $past(pkt.last))) // RL4
        else $error("data stored before frame start");
    branch_take_a: assert property (take && sync_c && fs && !s_q.wait_fs[pkt.ctx] && !buf_at_start[pkt.ctx]
            |=> frame_branch != 4'h0 ##1 frame_branch == 4'h0) // RL5
        else $error("frame branch pulse missing");
    sync_qualify_a: assert property (take && !s_q.drop
            && (s_q.keep[pkt.ctx] || !s_q.video[CTX_FIELD_W*pkt.ctx+STRIP_BIT]) |-> push) // RL6 RL7
        else $error("quadlet dropped while strip and sync disqualified");
    keep_set_a: assert property (reg_req && reg_we && reg_addr == CTX_CTRL_SET && reg_wdata[KEEP_HDR_BIT]
            && !(reg_addr == CTX_CTRL_CLR) |=> s_q.keep[0]) // RL8
        else $error("keep header set failed");
    link_alias_a: assert property (reg_req && reg_we && reg_addr == LINK_CLR_OFS && !eeprom_valid
            |=> (s_q.link & $past(reg_wdata)) == 32'h0) // RL9
        else $error("link clear alias failed");
    eeprom_load_a: assert property (eeprom_valid |=> (s_q.link & EEPROM_MASK) == ($past(eeprom_data) & EEPROM_MASK)) // RL11
        else $error("eeprom bits not loaded");
endmodule

// file: rvf_src.sv
`timescale 1ns/10ps

module rvf_src
    import rvf_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic pkt_ready,
    output logic      pkt_valid,
    output rvf_pkt_s  pkt
);
    initial
    begin
        pkt_valid = 1'b0;
        pkt       = '0;
    end

    // quadlets in order, each held until taken, last marks the end
    task automatic send(input logic [1:0] c, input logic [31:0] q[$]);
        @(posedge core_clk);
        foreach (q[i])
        begin
            pkt_valid <= 1'b1;
            pkt       <= '{data: q[i], ctx: c, last: (i == q.size() - 1)};
            @(posedge core_clk);
            while (!pkt_ready)
                @(posedge core_clk);
        end
        pkt_valid <= 1'b0;
        pkt       <= ~pkt;
    endtask
endmodule

// file: tb.sv
`timescale 1ns/10ps

module tb
    import rvf_pkg::*;
;
    logic        core_clk, rst_b, reg_req, reg_we, reg_cfg_sel, reg_ack, eeprom_valid;
    logic        pkt_valid, pkt_ready, out_valid, out_ready, se, ye, fs, ats;
    logic [7:0]  br_field;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, eeprom_data, r, d, stall;
    logic [3:0]  frame_branch, br_vec, ev, wt, buf_fill, at_start;
    logic [1:0]  c;
    rvf_pkt_s    pkt;
    rvf_word_s   out_word, exp_q[$];
    logic [31:0] q[$];
    int          fails, samples_checked, br_n, en;

    rvf_frame_sync rvf_frame_sync_inst (.core_clk(core_clk), .rst_b(rst_b), .reg_req(reg_req), .reg_we(reg_we),
        .reg_cfg_sel(reg_cfg_sel), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_ack(reg_ack), .eeprom_valid(eeprom_valid), .eeprom_data(eeprom_data), .desc_buffer_fill(buf_fill),
        .desc_branch(br_field), .buf_at_start(at_start), .pkt_valid(pkt_valid), .pkt_ready(pkt_ready), .pkt(pkt),
        .out_valid(out_valid), .out_ready(out_ready), .out_word(out_word), .frame_branch(frame_branch));
    rvf_src rvf_src_inst (.core_clk(core_clk), .pkt_ready(pkt_ready), .pkt_valid(pkt_valid), .pkt(pkt));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input logic [35:0] got, input logic [35:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic acc(input logic we, input logic [11:0] a, input logic [31:0] dt, input logic cfg);
        @(posedge core_clk);
        reg_req     <= 1'b1;
        reg_we      <= we;
        reg_addr    <= a;
        reg_wdata   <= dt;
        reg_cfg_sel <= cfg;
        @(posedge core_clk);
        reg_req <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic cfg);
        acc(1'b0, a, 32'h0, cfg);
        #1;
        check(36'({reg_ack, reg_rdata}), 36'({1'b1, e}));
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // far side stalls at random
    always @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            stall     <= 32'ha659;
            out_ready <= 1'b0;
            br_n      <= 0;
            br_vec    <= 4'h0;
        end
        else
        begin
            stall     <= lfsr(stall);
            out_ready <= stall[3] | stall[7];
            br_n      <= br_n + $countones(frame_branch);
            br_vec    <= br_vec | frame_branch;
            if (out_valid && out_ready)
                check(36'(out_word), 36'(exp_q.pop_front()));
        end
    end

    initial
    begin
        repeat (20000) @(posedge core_clk);
        fails++;
        conclude();
    end

    initial
    begin
        {rst_b, reg_req, reg_we, reg_cfg_sel, eeprom_valid} = '0;
        {reg_addr, reg_wdata, eeprom_data, ev, en, at_start} = '0;
        buf_fill = 4'hf;
        br_field = 8'h55;
        wt       = 4'hf;
        r        = 32'ha659;
        repeat (8) @(posedge core_clk);
        rst_b <= 1'b1;
        rd(VIDEO_SET_OFS, VIDEO_RESET, 1'b0);
        rd(LINK_CFG_OFS, LINK_RESET, 1'b1);
        acc(1'b1, VIDEO_SET_OFS, 32'hffff_ffff, 1'b0);
        rd(VIDEO_CLR_OFS, 32'h0000_3333, 1'b0);
        acc(1'b1, VIDEO_SET_OFS, 32'h0, 1'b0);
        acc(1'b1, VIDEO_CLR_OFS, 32'h0000_0f0f, 1'b0);
        rd(VIDEO_SET_OFS, 32'h0000_3030, 1'b0);
        // link tuning set up before link power is enabled
        acc(1'b1, LINK_SET_OFS, 32'hffff_ffff, 1'b0);
        acc(1'b1, LINK_CLR_OFS, 32'h0000_00f0, 1'b0);
        rd(LINK_CFG_OFS, 32'h0000_ff0f, 1'b1);
        acc(1'b1, LINK_CFG_OFS, 32'h1234_5678, 1'b1);
        rd(LINK_CLR_OFS, 32'h0000_5678, 1'b0);
        @(posedge core_clk);
        eeprom_valid <= 1'b1;
        eeprom_data  <= 32'hffff_abcd;
        @(posedge core_clk);
        eeprom_valid <= 1'b0;
        rd(LINK_SET_OFS, 32'h0000_abcd, 1'b0);
        rd(12'ha90, 32'h0, 1'b0);
        acc(1'b1, CTX_CTRL_SET + CTX_STRIDE, 32'hffff_ffff, 1'b0);
        rd(CTX_CTRL_CLR + CTX_STRIDE, 32'h4000_0000, 1'b0);
        $display("register test done");
        for (int t = 0; t < 16; t++)
        begin
            c = 2'(t + 1);
            acc(1'b1, VIDEO_CLR_OFS, 32'hffff_ffff, 1'b0);
            acc(1'b1, VIDEO_SET_OFS, {30'h0, t[1], t[0]} << (CTX_FIELD_W * c), 1'b0);
            acc(1'b1, (t[2] ? CTX_CTRL_SET : CTX_CTRL_CLR) + CTX_STRIDE * c, 32'h4000_0000, 1'b0);
            // upper half leaves buffer-fill mode or branch 01b, so sync must not act
            r        = lfsr(r);
            buf_fill <= (t[3] && r[0]) ? 4'h0 : 4'hf;
            br_field <= (t[3] && !r[0]) ? 8'haa : 8'h55;
            wt       = 4'hf;
            se = t[0] & ~t[2];
            ye = se & t[1] & ~t[3];
            for (int p = 0; p < 4; p++)
            begin
                q = {};
                // last packet lands at a buffer start, so its frame start is in place
                ats      = (p == 3);
                at_start <= {4{ats}};
                for (int i = 0; i < 5; i++)
                begin
                    r  = lfsr(r);
                    fs = (p > 0 && i == 2);
                    d  = fs ? {8'h1f, r[23:20], 4'h7, r[15:0]} : {8'h00, r[23:0]};
                    if (ye && fs && !wt[c] && !ats)
                    begin
                        en++;
                        ev[c] = 1'b1;
                    end
                    if (!ye)
                        wt[c] = 1'b1;
                    else if (fs)
                        wt[c] = 1'b0;
                    q.push_back(d);
                    if (!(se && i < 2) && !(ye && wt[c]))
                        exp_q.push_back('{data: d, ctx: c, frame_start: fs, last: (i == 4)});
                end
                rvf_src_inst.send(c, q);
            end
            repeat (300)
                if (exp_q.size() > 0)
                    @(posedge core_clk);
            repeat (4) @(posedge core_clk);
            check({br_n, br_vec}, {en, ev});
            $display("stream test %0d done", t);
        end
        conclude();
    end
endmodule
